// ===== shared/ctu_pkg.sv
// package for the charge time unit control block: register map, fields, types
package ctu_pkg;

  // ****************************************
  // register map (byte addresses, word per register)
  // ****************************************
  localparam logic [11:0] CTU_EDGE_SELECT_STATUS_LOW_IDX = 12'hFB2;
  localparam logic [11:0] CTU_UNIT_CONTROL_HIGH_IDX = 12'hFB3;
  localparam logic [11:0] CTU_DELAY_SOURCE_IDX = 12'hFB4;
  localparam logic [11:0] CTU_IRQ_STATUS_IDX = 12'hFB5;
  localparam logic [11:0] CTU_IRQ_MASK_IDX = 12'hFB6;
  localparam logic [13:0] CTU_ADDR_LOW = {CTU_EDGE_SELECT_STATUS_LOW_IDX, 2'b00};
  localparam logic [13:0] CTU_ADDR_HIGH = {CTU_UNIT_CONTROL_HIGH_IDX, 2'b00};
  localparam logic [13:0] CTU_ADDR_DSRC = {CTU_DELAY_SOURCE_IDX, 2'b00};
  localparam logic [13:0] CTU_ADDR_ISTAT = {CTU_IRQ_STATUS_IDX, 2'b00};
  localparam logic [13:0] CTU_ADDR_IMASK = {CTU_IRQ_MASK_IDX, 2'b00};

  // ****************************************
  // reset values, write mask and response codes
  // ****************************************
  localparam logic [7:0] CTU_LOW_RESET = 8'h00;
  localparam logic [7:0] CTU_HIGH_RESET = 8'h00;
  localparam logic [7:0] CTU_HIGH_WMASK = 8'hBF;
  localparam logic [1:0] CTU_RESP_OKAY = 2'h0;
  localparam logic [1:0] CTU_RESP_SLVERR = 2'h2;

  // ****************************************
  // edge source codes
  // ****************************************
  localparam logic [1:0] CTU_SRC_TIMER = 2'h0;
  localparam logic [1:0] CTU_SRC_COMPARE = 2'h1;
  localparam logic [1:0] CTU_SRC_PIN_TWO = 2'h2;
  localparam logic [1:0] CTU_SRC_PIN_ONE = 2'h3;

  // interrupt status bit positions
  localparam int CTU_IRQ_EDGE_ONE = 0;
  localparam int CTU_IRQ_EDGE_TWO = 1;
  localparam int CTU_IRQ_PULSE = 2;

  typedef struct packed {
    logic module_enable;
    logic unused6;
    logic stop_in_idle;
    logic time_generation_enable;
    logic edge_gate;
    logic edge_ordering_enable;
    logic discharge_control;
    logic trigger_enable;
  } ctu_ctrl_high_t;

  typedef struct packed {
    logic edge_two_polarity;
    logic [1:0] edge_two_source;
    logic edge_one_polarity;
    logic [1:0] edge_one_source;
    logic edge_two_flag;
    logic edge_one_flag;
  } ctu_ctrl_low_t;

  // edge inputs from the pins and internal sources
  typedef struct packed {
    logic external_edge_pin_one;
    logic external_edge_pin_two;
    logic compare_module_output;
    logic timer_one_module;
    logic delay_input_pin;
    logic comparator_two_out;
  } ctu_edges_t;

  // power state inputs
  typedef struct packed {
    logic sleep_mode;
    logic idle_mode;
  } ctu_power_t;

  // analog and trigger controls
  typedef struct packed {
    logic current_source_on;
    logic current_output_grounded;
    logic special_event_trigger;
    logic pulse_output_pin;
  } ctu_analog_t;

  // AXI4-Lite slave signals
  typedef struct packed {
    logic awvalid;
    logic [13:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [13:0] araddr;
    logic rready;
  } ctu_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctu_axi_rsp_t;

endpackage : ctu_pkg

// ===== verilog/ctu_edge_pulse_ctrl.sv
// charge time unit control: edge selection, edge flags, current source, pulse delay, AXI4-Lite registers
//
// Functional notes
// R1: time generation makes a clock-independent pulse from external input or comparator; here the pulse is one clock wide, after the two sync flops.
// R2: delay source clear follows comparator 2; set follows external delay pin.
// R3: comparator mode pulses once delay capacitor reaches the reference trip.
// R4: external mode pulses as soon as the delay input goes high.
// R5: software sets up comparator, enables time generation, then sets edge one flag.
// R6: any sleep mode disables the current source.
// R7: idle keeps running unless stop in idle set, which disables current source.
// R8: every reset clears all registers; unit disabled, source off.
// R9: after reset software pulses discharge control to drain the circuit.
// R10: module enable turns unit on or off; bit six reads zero.
// R11: edge gate passes selected edges when set, blocks all when clear.
// R12: ordering set means edge two counts only after edge one.
// R13: discharge control grounds the current source output while set.
// R14: trigger enable gates the special event trigger output.
// R15: polarity bit selects rising when set, falling when clear, per edge.
// R16: two-bit source: 11 pin one, 10 pin two, 01 compare, 00 timer.
// R17: edge flags set on their events and are software writable.
// R18: current source charges while edge one flag set and edge two clear.
`timescale 1ns/1ps

module ctu_edge_pulse_ctrl
  import ctu_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire ctu_pkg::ctu_axi_req_t axi_req,
  output ctu_pkg::ctu_axi_rsp_t axi_rsp,
  input wire ctu_pkg::ctu_edges_t edges_in,
  input wire ctu_pkg::ctu_power_t power_in,
  output ctu_pkg::ctu_analog_t analog_out,
  output logic irq
);
  import ctu_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ctu_edges_t sync1;
    ctu_edges_t sync2;
    ctu_power_t psync1;
    ctu_power_t psync2;
    logic [3:0] prev_src;
    logic prev_delay;
    ctu_ctrl_high_t high;
    ctu_ctrl_low_t low;
    logic delay_source_select;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic aw_got;
    logic [13:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    ctu_axi_rsp_t rsp;
    ctu_analog_t ana;
    logic irq;
  } ctu_state_t;

  ctu_state_t state_q;
  ctu_state_t state_d;

  logic [3:0] src_lvl;
  logic [1:0] edge_hit;

  // edge sources ordered by source code
  assign src_lvl = {state_q.sync2.external_edge_pin_one, state_q.sync2.external_edge_pin_two,
                    state_q.sync2.compare_module_output, state_q.sync2.timer_one_module};

  // ****************************************
  // per channel edge detection
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_edge
      logic [1:0] sel;
      logic pol;
      logic cur;
      logic prv;
      assign sel = (gi == 0) ? state_q.low.edge_one_source : state_q.low.edge_two_source; // R16
      assign pol = (gi == 0) ? state_q.low.edge_one_polarity : state_q.low.edge_two_polarity;
      assign cur = src_lvl[sel];
      assign prv = state_q.prev_src[sel];
      // rising when polarity set, falling when clear
      assign edge_hit[gi] = pol ? (cur & ~prv) : (~cur & prv); // R15
    end
  endgenerate

  always_comb begin
    logic ev1;
    logic ev2;
    logic pulse_src;
    logic pulse_fire;
    logic run;
    logic wr_go;
    logic rd_clr;
    logic [31:0] rd_val;
    logic [2:0] irq_set;
    ev1 = 1'b0;
    ev2 = 1'b0;
    pulse_src = 1'b0;
    pulse_fire = 1'b0;
    run = 1'b0;
    wr_go = 1'b0;
    rd_clr = 1'b0;
    rd_val = 32'h0000_0000;
    irq_set = 3'h0;
    state_d = state_q;

    // ****************************************
    // pin synchronisers
    // ****************************************
    state_d.sync1 = edges_in;
    state_d.sync2 = state_q.sync1;
    state_d.psync1 = power_in;
    state_d.psync2 = state_q.psync1;
    state_d.prev_src = src_lvl;

    // unit is active when module enable is set, unless sleeping or idle with stop in idle
    run = state_q.high.module_enable // R10
          & ~state_q.psync2.sleep_mode // R6
          & ~(state_q.psync2.idle_mode & state_q.high.stop_in_idle); // R7

    // ****************************************
    // edge events
    // ****************************************
    ev1 = run & state_q.high.edge_gate & edge_hit[0]; // R11
    ev2 = run & state_q.high.edge_gate & edge_hit[1]
          & (~state_q.high.edge_ordering_enable | state_q.low.edge_one_flag); // R12

    // ****************************************
    // pulse delay generation
    // ****************************************
    // the pulse is made in the clock domain: the analog edge is sampled, and the pulse lasts one clock
    pulse_src = state_q.delay_source_select ? state_q.sync2.delay_input_pin // R2 R4
                                            : state_q.sync2.comparator_two_out; // R3
    state_d.prev_delay = pulse_src;
    pulse_fire = run & state_q.high.time_generation_enable & state_q.low.edge_one_flag
                 & pulse_src & ~state_q.prev_delay; // R1

    // ****************************************
    // AXI4-Lite write
    // ****************************************
    if (axi_req.awvalid && state_q.rsp.awready) begin
      state_d.aw_got = 1'b1;
      state_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && state_q.rsp.wready) begin
      state_d.w_got = 1'b1;
      state_d.w_data = axi_req.wdata;
      state_d.w_strb = axi_req.wstrb;
    end
    wr_go = state_q.aw_got & state_q.w_got & ~state_q.rsp.bvalid;
    if (wr_go) begin
      state_d.aw_got = 1'b0;
      state_d.w_got = 1'b0;
      state_d.rsp.bvalid = 1'b1;
      state_d.rsp.bresp = CTU_RESP_OKAY;
      unique case (state_q.aw_addr)
        CTU_ADDR_LOW: begin
          if (state_q.w_strb[0]) begin
            state_d.low = ctu_ctrl_low_t'(state_q.w_data[7:0]); // R17
          end
        end
        CTU_ADDR_HIGH: begin
          if (state_q.w_strb[0]) begin
            state_d.high = ctu_ctrl_high_t'(state_q.w_data[7:0] & CTU_HIGH_WMASK); // R10
          end
        end
        CTU_ADDR_DSRC: begin
          if (state_q.w_strb[0]) begin
            state_d.delay_source_select = state_q.w_data[0];
          end
        end
        CTU_ADDR_IMASK: begin
          if (state_q.w_strb[0]) begin
            state_d.irq_mask = state_q.w_data[2:0];
          end
        end
        CTU_ADDR_ISTAT: begin
          state_d.rsp.bresp = CTU_RESP_OKAY;
        end
        default: begin
          state_d.rsp.bresp = CTU_RESP_SLVERR;
        end
      endcase
    end
    if (state_q.rsp.bvalid && axi_req.bready) begin
      state_d.rsp.bvalid = 1'b0;
    end
    state_d.rsp.awready = ~state_d.aw_got & ~state_d.rsp.bvalid;
    state_d.rsp.wready = ~state_d.w_got & ~state_d.rsp.bvalid;

    // ****************************************
    // AXI4-Lite read
    // ****************************************
    if (axi_req.arvalid && state_q.rsp.arready) begin
      state_d.rsp.rvalid = 1'b1;
      state_d.rsp.rresp = CTU_RESP_OKAY;
      unique case (axi_req.araddr)
        CTU_ADDR_LOW: rd_val = {24'h00_0000, state_q.low};
        CTU_ADDR_HIGH: rd_val = {24'h00_0000, state_q.high};
        CTU_ADDR_DSRC: rd_val = {31'h0000_0000, state_q.delay_source_select};
        CTU_ADDR_IMASK: rd_val = {29'h0000_0000, state_q.irq_mask};
        CTU_ADDR_ISTAT: begin
          rd_val = {29'h0000_0000, state_q.irq_status};
          rd_clr = 1'b1;
        end
        default: state_d.rsp.rresp = CTU_RESP_SLVERR;
      endcase
      state_d.rsp.rdata = rd_val;
    end
    if (state_q.rsp.rvalid && axi_req.rready) begin
      state_d.rsp.rvalid = 1'b0;
    end
    state_d.rsp.arready = ~state_d.rsp.rvalid;

    // ****************************************
    // edge flags: hardware set wins over a software clear in the same cycle
    // ****************************************
    if (ev1) begin
      state_d.low.edge_one_flag = 1'b1; // R17
    end
    if (ev2) begin
      state_d.low.edge_two_flag = 1'b1; // R17
    end

    // ****************************************
    // interrupts: sticky, cleared by reading, new events win
    // ****************************************
    irq_set[CTU_IRQ_EDGE_ONE] = ev1;
    irq_set[CTU_IRQ_EDGE_TWO] = ev2;
    irq_set[CTU_IRQ_PULSE] = pulse_fire;
    state_d.irq_status = (rd_clr ? 3'h0 : state_q.irq_status) | irq_set;
    state_d.irq = |(state_d.irq_status & state_d.irq_mask);

    // ****************************************
    // analog controls
    // ****************************************
    state_d.ana.current_source_on = run & state_q.low.edge_one_flag & ~state_q.low.edge_two_flag; // R18
    state_d.ana.current_output_grounded = state_q.high.discharge_control; // R13
    // trigger fires when the measurement window closes on edge two
    state_d.ana.special_event_trigger = state_q.high.trigger_enable & ev2; // R14
    state_d.ana.pulse_output_pin = pulse_fire; // R1
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '0; // R8
      state_q.high <= ctu_ctrl_high_t'(CTU_HIGH_RESET);
      state_q.low <= ctu_ctrl_low_t'(CTU_LOW_RESET);
    end else begin
      state_q <= state_d;
    end
  end

  assign axi_rsp = state_q.rsp;
  assign analog_out = state_q.ana;
  assign irq = state_q.irq;

endmodule : ctu_edge_pulse_ctrl

// ===== tb/ctu_edge_pulse_checker.sv
// concurrent checks on the ports of the charge time unit control block
`timescale 1ns/1ps
module ctu_edge_pulse_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire ctu_pkg::ctu_axi_req_t axi_req,
  input wire ctu_pkg::ctu_axi_rsp_t axi_rsp,
  input wire ctu_pkg::ctu_power_t power_in,
  input wire ctu_pkg::ctu_analog_t analog_out,
  input wire logic irq
);
  import ctu_pkg::*;
  // ****************************************
  // bus handshake, reset and output pulses
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  a_bresp_stands: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response withdrawn");
  a_rdata_stands: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data withdrawn");
  a_write_busy: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while answer pending");
  a_read_busy: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while answer pending");
  a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##[1:3] axi_rsp.bvalid) else $error("write answer late");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_reset_clear: assert property ($fell(sys_rst) |-> !analog_out.current_source_on && !irq && !axi_rsp.rvalid)
    else $error("state left after reset");
  a_sleep_off: assert property (power_in.sleep_mode [*6] |-> !analog_out.current_source_on)
    else $error("current on in sleep");
  a_pulse_one: assert property (analog_out.pulse_output_pin |=> !analog_out.pulse_output_pin)
    else $error("pulse longer than a cycle");
  a_trig_one: assert property (analog_out.special_event_trigger |=> !analog_out.special_event_trigger)
    else $error("trigger longer than a cycle");
  c_pulse: cover property (analog_out.pulse_output_pin);
  c_trig: cover property (analog_out.special_event_trigger);
  c_irq: cover property (irq);
endmodule : ctu_edge_pulse_checker

bind ctu_edge_pulse_ctrl ctu_edge_pulse_checker u_chk (.clock(clock), .sys_rst(sys_rst), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .power_in(power_in), .analog_out(analog_out), .irq(irq));

// ===== tb/ctu_edge_model.sv
// far side model: edge pins, compare and timer outputs, delay pin and comparator
`timescale 1ns/1ps
module ctu_edge_model (
  input wire logic clock,
  input wire logic [5:0] lvl,
  output ctu_pkg::ctu_edges_t edges
);
  import ctu_pkg::*;
  // sources change just after an edge, as a peripheral output register would
  initial edges = '0;
  always @(posedge clock)
    edges <= lvl;
endmodule : ctu_edge_model

// ===== tb/ctu_edge_pulse_ctrl_tb.sv
// self-checking bench for the charge time unit control block
`timescale 1ns/1ps
module ctu_edge_pulse_ctrl_tb;
  import ctu_pkg::*;
  logic clock;
  logic sys_rst;
  logic irq;
  logic [5:0] lvl;
  ctu_axi_req_t req;
  ctu_axi_rsp_t rsp;
  ctu_edges_t edg;
  ctu_power_t pwr;
  ctu_analog_t ana;
  logic [33:0] exp_q[$];
  int num_errors = 0;
  int num_checks = 0;
  int pulses = 0;
  int trigs = 0;

  ctu_edge_pulse_ctrl u_dut (.clock(clock), .sys_rst(sys_rst), .axi_req(req), .axi_rsp(rsp), .edges_in(edg),
    .power_in(pwr), .analog_out(ana), .irq(irq));
  ctu_edge_model u_src (.clock(clock), .lvl(lvl), .edges(edg));

  always #25 clock = ~clock;

  // ****************************************
  // checking, bus tasks and monitor
  // ****************************************
  task automatic conclude;
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [33:0] got, input logic [33:0] want);
    num_checks++;
    if (got !== want) begin
      num_errors++;
      $display("[ERR] t=%0t got %h want %h", $time, got, want);
    end
  endtask : check

  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    @(posedge clock);
    req.awaddr <= a;
    req.wdata <= {24'($urandom()), d};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    n = 0;
    while ((req.awvalid || req.wvalid || !rsp.bvalid) && n < 50) begin
      @(posedge clock);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    check(34'(rsp.bresp), 34'(r));
    if (n >= 50) begin
      num_errors++;
      conclude();
    end
  endtask : wr

  task automatic rd(input logic [13:0] a, input logic [9:0] e);
    int n;
    @(posedge clock);
    exp_q.push_back({e[9:8], 24'h0, e[7:0]});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    n = 0;
    while (!(rsp.rvalid && req.rready) && n < 50) begin
      @(posedge clock);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      conclude();
    end
  endtask : rd

  // source levels are seen by the block after its two sync flops, so allow eight cycles
  task automatic sig(input int i, input logic v);
    lvl[i] <= v;
    repeat (8) @(posedge clock);
  endtask : sig

  always @(posedge clock) begin
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
      check({rsp.rresp, rsp.rdata}, exp_q.pop_front());
    if (ana.pulse_output_pin === 1'b1) pulses++;
    if (ana.special_event_trigger === 1'b1) trigs++;
  end

  initial begin
    logic [7:0] b;
    clock = 1'b0;
    sys_rst = 1'b1;
    req = '0;
    pwr = '0;
    lvl = '0;
    void'($urandom(34));
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    rd(CTU_ADDR_HIGH, 10'h000);
    rd(CTU_ADDR_LOW, 10'h000);
    wr(CTU_ADDR_HIGH, 8'hFF, CTU_RESP_OKAY);
    rd(CTU_ADDR_HIGH, 10'h0BF);
    check(34'(ana.current_output_grounded), 34'h1);
    wr(14'h0010, 8'h55, CTU_RESP_SLVERR);
    rd(14'h0010, 10'h200);
    wr(CTU_ADDR_HIGH, 8'h8C, CTU_RESP_OKAY);
    // the grounding output follows the register one cycle after the write lands
    repeat (2) @(posedge clock);
    check(34'(ana.current_output_grounded), 34'h0);
    // edge one rises on source c, edge two falls on the same source
    for (int c = 0; c < 4; c++) begin
      b = {1'b0, 2'(c), 1'b1, 2'(c), 2'b00};
      wr(CTU_ADDR_LOW, b, CTU_RESP_OKAY);
      sig(((c + 1) % 4) + 2, 1'b1);
      rd(CTU_ADDR_LOW, {2'b00, b});
      sig(c + 2, 1'b1);
      rd(CTU_ADDR_LOW, {2'b00, b | 8'h01});
      check(34'(ana.current_source_on), 34'h1);
      lvl <= '0;
      repeat (8) @(posedge clock);
      rd(CTU_ADDR_LOW, {2'b00, b | 8'h03});
      check(34'(ana.current_source_on), 34'h0);
    end
    wr(CTU_ADDR_HIGH, 8'h8D, CTU_RESP_OKAY);
    wr(CTU_ADDR_LOW, 8'hDC, CTU_RESP_OKAY);
    sig(4, 1'b1);
    rd(CTU_ADDR_LOW, 10'h0DC);
    check(34'(trigs), 34'h0);
    sig(4, 1'b0);
    sig(5, 1'b1);
    sig(4, 1'b1);
    rd(CTU_ADDR_LOW, 10'h0DF);
    check(34'(trigs), 34'h1);
    lvl <= '0;
    wr(CTU_ADDR_HIGH, 8'h80, CTU_RESP_OKAY);
    wr(CTU_ADDR_LOW, 8'hDC, CTU_RESP_OKAY);
    sig(5, 1'b1);
    rd(CTU_ADDR_LOW, 10'h0DC);
    wr(CTU_ADDR_IMASK, 8'h01, CTU_RESP_OKAY);
    repeat (2) @(posedge clock);
    check(34'(irq), 34'h1);
    rd(CTU_ADDR_ISTAT, 10'h003);
    repeat (2) @(posedge clock);
    check(34'(irq), 34'h0);
    lvl <= '0;
    wr(CTU_ADDR_LOW, 8'h01, CTU_RESP_OKAY);
    repeat (2) @(posedge clock);
    check(34'(ana.current_source_on), 34'h1);
    pwr.idle_mode <= 1'b1;
    repeat (8) @(posedge clock);
    check(34'(ana.current_source_on), 34'h1);
    wr(CTU_ADDR_HIGH, 8'hA0, CTU_RESP_OKAY);
    repeat (8) @(posedge clock);
    check(34'(ana.current_source_on), 34'h0);
    pwr.idle_mode <= 1'b0;
    pwr.sleep_mode <= 1'b1;
    wr(CTU_ADDR_HIGH, 8'h80, CTU_RESP_OKAY);
    repeat (8) @(posedge clock);
    check(34'(ana.current_source_on), 34'h0);
    pwr.sleep_mode <= 1'b0;
    repeat (8) @(posedge clock);
    check(34'(ana.current_source_on), 34'h1);
    wr(CTU_ADDR_DSRC, 8'h00, CTU_RESP_OKAY);
    wr(CTU_ADDR_HIGH, 8'h90, CTU_RESP_OKAY);
    wr(CTU_ADDR_LOW, 8'h01, CTU_RESP_OKAY);
    sig(0, 1'b1);
    check(34'(pulses), 34'h1);
    wr(CTU_ADDR_DSRC, 8'h01, CTU_RESP_OKAY);
    sig(0, 1'b0);
    sig(0, 1'b1);
    check(34'(pulses), 34'h1);
    sig(1, 1'b1);
    check(34'(pulses), 34'h2);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    rd(CTU_ADDR_HIGH, 10'h000);
    rd(CTU_ADDR_DSRC, 10'h000);
    conclude();
  end
endmodule : ctu_edge_pulse_ctrl_tb
